// [pkg/uecr_cfg.svh]
/*
 * Register map and field constants for the endpoint configuration bank.
 * Assumes inclusion by bare name from the package and the core.
 */
`ifndef UECR_CFG_SVH
`define UECR_CFG_SVH

`define UECR_ADDR_W          8
`define UECR_DATA_W          16
`define UECR_IDX_W           4
`define UECR_NUM_EP          16
`define UECR_OFF_MAXPKT      8'h04
`define UECR_OFF_TYPE        8'h08
`define UECR_OFF_BYTECNT     8'h1C
`define UECR_RST_16          16'h0000
`define UECR_FIFO_LSB        0
`define UECR_FIFO_MSB        10
`define UECR_NTR_LSB         11
`define UECR_NTR_MSB         12
`define UECR_MAXPKT_MASK     16'h1FFF
`define UECR_TYPE_MASK       16'h001F
`define UECR_BIT_SUPPRESS    4
`define UECR_BIT_ENABLE      3
`define UECR_BIT_DOUBLE_BUFFER_ENABLE      2
`define UECR_TYP_LSB         0
`define UECR_TYP_MSB         1
`define UECR_NTR_RESERVED    2'h3
`define UECR_NTR_ONE         2'h0
`define UECR_CTRL_EP         4'h0

`endif

// [pkg/uecr_pkg.sv]
/*
 * Types for the endpoint configuration bank.
 * Assumes uecr_cfg.svh is on the include path.
 */
`include "uecr_cfg.svh"

package uecr_pkg;
    typedef enum logic [1:0] {
        UECR_TYP_NONE = 2'h0,
        UECR_TYP_ISO  = 2'h1,
        UECR_TYP_BULK = 2'h2,
        UECR_TYP_INTR = 2'h3
    } uecr_type_t;
endpackage

// [core/uecr_regs.sv]
/*
 * Per-endpoint configuration registers: packet byte count, max packet
 * size and endpoint type, indexed by the endpoint index on the host port.
 * Assumes a synchronous parallel register port on clock_in, a USB bus
 * reset pulse from the engine on the same clock, and a separate OUT-ACK
 * load strobe from the engine.
 */
`timescale 1ns/100ps
`default_nettype none
`include "uecr_cfg.svh"

module uecr_regs (
    input  wire logic                     clock_in,
    input  wire logic                     rst_in,
    input  wire logic                     clk_en_in,
    input  wire logic                     bus_reset_in,
    input  wire logic [`UECR_IDX_W-1:0]   ep_index_in,
    input  wire logic [`UECR_ADDR_W-1:0]  addr_in,
    input  wire logic                     wr_in,
    input  wire logic                     rd_in,
    input  wire logic [`UECR_DATA_W-1:0]  wdata_in,
    input  wire logic                     out_ack_in,
    input  wire logic [`UECR_IDX_W-1:0]   out_ack_ep_in,
    input  wire logic [`UECR_DATA_W-1:0]  out_ack_count_in,
    input  wire logic                     dma_mode_in,
    input  wire logic [`UECR_IDX_W-1:0]   eng_ep_in,
    output logic      [`UECR_DATA_W-1:0]  rdata_out,
    output logic                          rvalid_out,
    output logic      [`UECR_DATA_W-1:0]  eng_byte_count_out,
    output logic      [10:0]              eng_fifo_size_out,
    output logic      [1:0]               eng_packets_out,
    output logic                          eng_enable_out,
    output logic                          eng_double_buffer_out,
    output uecr_pkg::uecr_type_t          eng_type_out,
    output logic                          eng_empty_packet_out
);

    ////////////////////////////////////////////////////////////////////////
    // Storage
    logic [`UECR_DATA_W-1:0] count_reg  [`UECR_NUM_EP];
    logic [`UECR_DATA_W-1:0] count_next [`UECR_NUM_EP];
    logic [`UECR_DATA_W-1:0] maxpkt_reg  [`UECR_NUM_EP];
    logic [`UECR_DATA_W-1:0] maxpkt_next [`UECR_NUM_EP];
    logic [`UECR_DATA_W-1:0] type_reg  [`UECR_NUM_EP];
    logic [`UECR_DATA_W-1:0] type_next [`UECR_NUM_EP];

    logic wr_maxpkt;
    logic wr_type;
    logic wr_count;

    // Address decode; other offsets ignored, read back zero
    assign wr_maxpkt = wr_in && (addr_in == `UECR_OFF_MAXPKT);
    assign wr_type   = wr_in && (addr_in == `UECR_OFF_TYPE);
    assign wr_count  = wr_in && (addr_in == `UECR_OFF_BYTECNT);

    ////////////////////////////////////////////////////////////////////////
    // Per-endpoint next values
    genvar g;
    generate
        for (g = 0; g < `UECR_NUM_EP; g++) begin : g_ep
            localparam logic [`UECR_IDX_W-1:0] EP = `UECR_IDX_W'(g);

            // Bus reset clears all three registers of every endpoint
            always_comb begin
                count_next[g]  = count_reg[g];
                maxpkt_next[g] = maxpkt_reg[g];
                type_next[g]   = type_reg[g];
                if (bus_reset_in) begin
                    count_next[g]  = `UECR_RST_16;
                    maxpkt_next[g] = `UECR_RST_16;
                    type_next[g]   = `UECR_RST_16;
                end else begin
                    // Control endpoint zero keeps its fixed size
                    if (wr_maxpkt && ep_index_in == EP && EP != `UECR_CTRL_EP) begin
                        maxpkt_next[g] = wdata_in & `UECR_MAXPKT_MASK;
                    end
                    if (wr_type && ep_index_in == EP) begin
                        type_next[g] = wdata_in & `UECR_TYPE_MASK;
                    end
                    // Reload uses the newly written FIFO size, all endpoints
                    if (wr_maxpkt) begin
                        count_next[g] = {5'h00,
                            wdata_in[`UECR_FIFO_MSB:`UECR_FIFO_LSB]};
                    end
                    if (wr_count && ep_index_in == EP) begin
                        count_next[g] = wdata_in;
                    end
                    // Engine load wins over software: it reports real traffic
                    if (out_ack_in && out_ack_ep_in == EP) begin
                        count_next[g] = out_ack_count_in;
                    end
                end
            end

            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    count_reg[g]  <= `UECR_RST_16;
                    maxpkt_reg[g] <= `UECR_RST_16;
                    type_reg[g]   <= `UECR_RST_16;
                end else if (clk_en_in) begin
                    count_reg[g]  <= count_next[g];
                    maxpkt_reg[g] <= maxpkt_next[g];
                    type_reg[g]   <= type_next[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read port and engine view
    logic [`UECR_DATA_W-1:0]  rdata_next;
    logic                     rvalid_next;
    logic [`UECR_DATA_W-1:0]  eng_cnt_next;
    logic [10:0]              eng_fifo_next;
    logic [1:0]               eng_pk_next;
    logic                     eng_en_next;
    logic                     eng_db_next;
    uecr_pkg::uecr_type_t     eng_typ_next;
    logic                     eng_emp_next;
    logic [`UECR_DATA_W-1:0]  sel_mp;
    logic [`UECR_DATA_W-1:0]  sel_ty;
    logic [1:0]               ntr;

    always_comb begin
        rdata_next  = `UECR_RST_16;
        rvalid_next = rd_in;
        if (rd_in) begin
            case (addr_in)
                `UECR_OFF_MAXPKT:  rdata_next = maxpkt_reg[ep_index_in];
                `UECR_OFF_TYPE:    rdata_next = type_reg[ep_index_in];
                `UECR_OFF_BYTECNT: rdata_next = count_reg[ep_index_in];
                default:           rdata_next = `UECR_RST_16;
            endcase
        end
        sel_mp = maxpkt_reg[eng_ep_in];
        sel_ty = type_reg[eng_ep_in];
        eng_cnt_next  = count_reg[eng_ep_in];
        eng_fifo_next = sel_mp[`UECR_FIFO_MSB:`UECR_FIFO_LSB];
        ntr = sel_mp[`UECR_NTR_MSB:`UECR_NTR_LSB];
        // Reserved code degrades to one packet per microframe
        eng_pk_next = (ntr == `UECR_NTR_RESERVED) ? `UECR_NTR_ONE : ntr;
        eng_en_next = sel_ty[`UECR_BIT_ENABLE];
        eng_db_next = sel_ty[`UECR_BIT_DOUBLE_BUFFER_ENABLE];
        eng_typ_next = uecr_pkg::uecr_type_t'(sel_ty[`UECR_TYP_MSB:`UECR_TYP_LSB]);
        // Empty packet only in DMA mode, suppress clear, count or size zero
        eng_emp_next = dma_mode_in && !sel_ty[`UECR_BIT_SUPPRESS]
                       && (eng_cnt_next == `UECR_RST_16
                           || eng_fifo_next == 11'h000);
    end

    // Registered outputs, one cycle behind the selected state
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out             <= `UECR_RST_16;
            rvalid_out            <= 1'b0;
            eng_byte_count_out    <= `UECR_RST_16;
            eng_fifo_size_out     <= 11'h000;
            eng_packets_out       <= 2'h0;
            eng_enable_out        <= 1'b0;
            eng_double_buffer_out <= 1'b0;
            eng_type_out          <= uecr_pkg::UECR_TYP_NONE;
            eng_empty_packet_out  <= 1'b0;
        end else if (clk_en_in) begin
            rdata_out             <= rdata_next;
            rvalid_out            <= rvalid_next;
            eng_byte_count_out    <= eng_cnt_next;
            eng_fifo_size_out     <= eng_fifo_next;
            eng_packets_out       <= eng_pk_next;
            eng_enable_out        <= eng_en_next;
            eng_double_buffer_out <= eng_db_next;
            eng_type_out          <= eng_typ_next;
            eng_empty_packet_out  <= eng_emp_next;
        end
    end

endmodule
`default_nettype wire

// [sim/uecr_regs_sva.sv]
/* Concurrent checks on the endpoint configuration bank's ports.
   Assumes a bind from the bench and one clock domain on clock_in. */
`timescale 1ns/100ps
`default_nettype none
module uecr_regs_chk (
    input wire logic        clock_in,
    input wire logic        rst_in,
    input wire logic        clk_en_in,
    input wire logic        bus_reset_in,
    input wire logic [3:0]  ep_index_in,
    input wire logic [7:0]  addr_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic        out_ack_in,
    input wire logic        dma_mode_in,
    input wire logic [15:0] rdata_out,
    input wire logic        rvalid_out,
    input wire logic [15:0] eng_byte_count_out,
    input wire logic [1:0]  eng_packets_out,
    input wire logic        eng_enable_out,
    input wire logic        eng_empty_packet_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////
    // Read strobe answered exactly one cycle later
    chk_read_answer: assert property ((rd_in && clk_en_in) |=> rvalid_out)
        else $error("read not answered");
    chk_no_spurious: assert property ((!rd_in && clk_en_in) |=> !rvalid_out)
        else $error("answer without read");
    chk_mps_reserved: assert property ((rvalid_out && $past(addr_in) == 8'h04)
        |-> rdata_out[15:13] == 3'h0) else $error("max packet reserved bits set");
    chk_type_reserved: assert property ((rvalid_out && $past(addr_in) == 8'h08)
        |-> rdata_out[15:5] == 11'h000) else $error("type reserved bits set");
    chk_ep0_fixed: assert property ((rvalid_out && $past(addr_in) == 8'h04
        && $past(ep_index_in) == 4'h0) |-> rdata_out == 16'h0000)
        else $error("control endpoint size stored");
    // Bus reset must leave the engine view empty two edges on
    chk_bus_clear: assert property (((bus_reset_in && clk_en_in) ##1
        (!wr_in && !out_ack_in)) |=> (eng_byte_count_out == 16'h0000 && !eng_enable_out))
        else $error("bus reset left state");
    chk_packets_code: assert property (eng_packets_out != 2'h3)
        else $error("reserved packet code shown");
    chk_empty_dma: assert property (!$past(dma_mode_in) |-> !eng_empty_packet_out)
        else $error("empty packet outside dma mode");
    cover property (rvalid_out);
    cover property (bus_reset_in);
    cover property (eng_empty_packet_out);
endmodule
`default_nettype wire

// [sim/uecr_eng_model.sv]
/* USB engine stand-in: raises OUT acknowledge pulses with byte counts.
   Assumes calls are made at a falling clock edge. */
`timescale 1ns/100ps
`default_nettype none
module uecr_eng_model (
    input  wire logic        clock_in,
    output logic             ack_out,
    output logic [3:0]       ep_out,
    output logic [15:0]      count_out
);
    initial begin
        ack_out = 1'b0;
        ep_out = 4'h0;
        count_out = 16'h0000;
    end
    // One-cycle pulse; count is scrambled afterwards so a stale value never passes
    task automatic send(input logic [3:0] ep, input logic [15:0] cnt);
        ep_out = ep;
        count_out = cnt;
        ack_out = 1'b1;
        @(negedge clock_in);
        ack_out = 1'b0;
        count_out = ~cnt;
    endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
/* Self-checking bench for the endpoint configuration bank.
   Assumes the engine model and the checker are compiled alongside. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clock_in = 0, rst_in = 1, bus_reset = 0, wr = 0, rd = 0, dma = 0, ack;
    logic [3:0] idx = 0, eng_ep = 0, ack_ep;
    logic [7:0] addr = 0;
    logic [15:0] wdata = 0, ack_cnt, rdata_out, eng_byte_count_out;
    logic [10:0] eng_fifo_size_out;
    logic [1:0] eng_packets_out;
    logic rvalid_out, eng_enable_out, eng_double_buffer_out, eng_empty_packet_out;
    uecr_pkg::uecr_type_t eng_type_out;
    int bad_count = 0, tests_run = 0, cyc = 0;
    always #12.5 clock_in = ~clock_in;
    uecr_eng_model u_uecr_eng_model (.clock_in(clock_in), .ack_out(ack), .ep_out(ack_ep),
        .count_out(ack_cnt));
    uecr_regs u_uecr_regs (.clock_in(clock_in), .rst_in(rst_in), .clk_en_in(1'b1),
        .bus_reset_in(bus_reset), .ep_index_in(idx), .addr_in(addr), .wr_in(wr), .rd_in(rd),
        .wdata_in(wdata), .out_ack_in(ack), .out_ack_ep_in(ack_ep), .out_ack_count_in(ack_cnt),
        .dma_mode_in(dma), .eng_ep_in(eng_ep), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
        .eng_byte_count_out(eng_byte_count_out), .eng_fifo_size_out(eng_fifo_size_out),
        .eng_packets_out(eng_packets_out), .eng_enable_out(eng_enable_out),
        .eng_double_buffer_out(eng_double_buffer_out), .eng_type_out(eng_type_out),
        .eng_empty_packet_out(eng_empty_packet_out));
    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Hang guard: whole sequence needs well under 400 cycles
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [15:0] exp, input logic [15:0] got, input string n);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask
    // Strobes go up and down on falling edges, one rising edge apart
    task automatic wrr(input logic [7:0] a, input logic [3:0] i, input logic [15:0] d);
        {addr, idx, wdata, wr} = {a, i, d, 1'b1};
        @(negedge clock_in);
        wr = 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [3:0] i, input logic [15:0] e);
        {addr, idx, rd} = {a, i, 1'b1};
        @(negedge clock_in);
        rd = 1'b0;
        chk(16'h0001, {15'h0000, rvalid_out}, "rvalid");
        chk(e, rdata_out, "rdata");
    endtask
    task automatic eng(input logic [3:0] i);
        eng_ep = i;
        repeat (2) @(negedge clock_in);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge clock_in);
        rst_in = 1'b0;
        rdc(8'h04, 4'h1, 16'h0000);
        rdc(8'h08, 4'h1, 16'h0000);
        rdc(8'h1C, 4'h1, 16'h0000);
        wrr(8'h04, 4'h2, 16'hFFFF);
        rdc(8'h04, 4'h2, 16'h1FFF);
        rdc(8'h1C, 4'h5, 16'h07FF);
        eng(4'h2);
        chk(16'h07FF, {5'h00, eng_fifo_size_out}, "fifo_size");
        // Every packet code, reserved one shown as single packet
        for (int k = 0; k < 4; k++) begin
            wrr(8'h04, 4'h2, {3'h0, k[1:0], 11'h040});
            eng(4'h2);
            chk((k == 3) ? 16'h0000 : 16'(k), {14'h0, eng_packets_out}, "packets");
        end
        wrr(8'h04, 4'h0, 16'h0080);
        rdc(8'h04, 4'h0, 16'h0000);
        rdc(8'h1C, 4'h3, 16'h0080);
        for (int k = 1; k < 4; k++) begin
            wrr(8'h08, 4'h2, 16'hFFFC | 16'(k));
            rdc(8'h08, 4'h2, 16'h001C | 16'(k));
            eng(4'h2);
            chk(16'(k), {14'h0, eng_type_out}, "type");
            chk(16'h0003, {14'h0, eng_enable_out, eng_double_buffer_out}, "en_dbl");
        end
        rdc(8'h08, 4'h3, 16'h0000);
        u_uecr_eng_model.send(4'h2, 16'h0123);
        rdc(8'h1C, 4'h2, 16'h0123);
        wrr(8'h1C, 4'h2, 16'hBEEF);
        rdc(8'h1C, 4'h2, 16'hBEEF);
        wrr(8'h24, 4'h2, 16'hFFFF);
        rdc(8'h24, 4'h2, 16'h0000);
        dma = 1'b1;
        wrr(8'h1C, 4'h2, 16'h0000);
        wrr(8'h08, 4'h2, 16'h000A);
        eng(4'h2);
        chk(16'h0001, {15'h0, eng_empty_packet_out}, "empty_pkt");
        wrr(8'h08, 4'h2, 16'h0012);
        eng(4'h2);
        chk(16'h0000, {14'h0, eng_empty_packet_out, eng_enable_out}, "suppress");
        bus_reset = 1'b1;
        @(negedge clock_in);
        bus_reset = 1'b0;
        rdc(8'h08, 4'h2, 16'h0000);
        report_and_stop();
    end
endmodule
bind uecr_regs uecr_regs_chk u_uecr_regs_chk (.clock_in, .rst_in, .clk_en_in, .bus_reset_in,
    .ep_index_in, .addr_in, .wr_in, .rd_in, .out_ack_in, .dma_mode_in, .rdata_out, .rvalid_out,
    .eng_byte_count_out, .eng_packets_out, .eng_enable_out, .eng_empty_packet_out);
`default_nettype wire
